// ==== opac_defs.vh ====
// opac_defs.vh: offsets, field positions, reset values and timing counts
// of the output port and gain loop control block
// assumes: included by bare name from every opac design file
`ifndef OPAC_DEFS_VH
`define OPAC_DEFS_VH
// indirect register indices (written into the channel address pointer)
`define OPAC_IDX_HB_A 8'h08
`define OPAC_IDX_HB_B 8'h09
`define OPAC_IDX_GLA_CTRL 8'h0A
`define OPAC_IDX_GLA_HOLD 8'h0B
`define OPAC_IDX_GLA_LEVEL 8'h0C
`define OPAC_IDX_GLA_SGAIN 8'h0D
`define OPAC_IDX_GLA_KGAIN 8'h0E
`define OPAC_IDX_GLA_POLE 8'h0F
`define OPAC_IDX_GLA_AVG 8'h10
`define OPAC_IDX_GLA_DEC 8'h11
`define OPAC_IDX_GLB_KGAIN 8'h16
`define OPAC_IDX_GLB_POLE 8'h17
`define OPAC_IDX_GLB_AVG 8'h18
`define OPAC_IDX_GLB_DEC 8'h19
`define OPAC_IDX_PP_A 8'h1A
`define OPAC_IDX_LNK_A 8'h1B
`define OPAC_IDX_PP_B 8'h1C
`define OPAC_IDX_LNK_B 8'h1D
`define OPAC_IDX_PCLK 8'h1E
// half-band port control fields
`define OPAC_HB_BYPASS 0
`define OPAC_HBA_IL_LSB 1
`define OPAC_HBA_EN 3
`define OPAC_HBB_IL 1
`define OPAC_HBB_EN 2
// gain loop control fields
`define OPAC_GL_BYPASS 0
`define OPAC_GL_FIRST_ONLY 1
`define OPAC_GL_INIT_SYNC 2
`define OPAC_GL_SYNC_NOW 3
`define OPAC_GL_CLIP_MODE 4
`define OPAC_GL_WLEN_LSB 5
// parallel port control fields
`define OPAC_PP_SRC 0
`define OPAC_PP_EN_LSB 1
`define OPAC_PP_FMT8 5
// link port control fields
`define OPAC_LK_SRC 0
`define OPAC_LK_TWO_CH 1
`define OPAC_LK_NO_RSSI 2
`define OPAC_LK_WAIT_LSB 3
`define OPAC_LK_EN 7
// port clock control fields
`define OPAC_PC_MASTER 0
`define OPAC_PC_DIV_LSB 1
// reset values
`define OPAC_RST_HB 4'h0
`define OPAC_RST_GL_CTRL 8'h00
`define OPAC_RST_HOLD 16'h0000
`define OPAC_RST_PARAM 12'h000
`define OPAC_RST_PP 6'h00
`define OPAC_RST_LNK 8'h00
`define OPAC_RST_PCLK 3'h0
// timing counts
`define OPAC_SYNC_STAGES 2
`endif

// ==== opac_interleave.v ====
// opac_interleave.v: channel interleave and interpolate-by-two slot sequencer
// assumes: slot_stb marks one output slot; channels start at BASE
`timescale 1ns/1ps
`include "opac_defs.vh"
module opac_interleave #(
  parameter [1:0] BASE = 2'h0
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire slot_stb,
  input wire [1:0] last_idx,
  input wire bypass,
  output reg [1:0] chan,
  output reg interp_phase,
  output reg out_stb
);
  reg [1:0] idx;
  wire [1:0] cur_idx;
  assign cur_idx = (idx > last_idx) ? 2'h0 : idx;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx <= 2'h0;
      interp_phase <= 1'b0;
      chan <= 2'h0;
      out_stb <= 1'b0;
    end else if (ce) begin
      out_stb <= slot_stb;
      if (slot_stb) begin
        chan <= BASE + cur_idx;
        // two slots per channel when filtering
        if (bypass || interp_phase) begin
          interp_phase <= 1'b0;
          idx <= (cur_idx >= last_idx) ? 2'h0 : cur_idx + 2'h1;
        end else begin
          interp_phase <= 1'b1;
          idx <= cur_idx;
        end
      end
    end
  end
endmodule // opac_interleave

// ==== opac_output_ctrl.v ====
// assumes: microport strobes and data on clk; sync and port clock pins asynchronous
`timescale 1ns/1ps
`include "opac_defs.vh"
module opac_output_ctrl (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire io_access_en,
  input wire ptr_wr,
  input wire [7:0] ptr_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  input wire sync_pin,
  input wire soft_sync,
  input wire slot_a_stb,
  input wire slot_b_stb,
  input wire [22:0] hb_a_sample,
  input wire [22:0] gain_a_sample,
  input wire sample_a_valid,
  output reg [15:0] out_a_data,
  output reg out_a_valid,
  output wire [1:0] hb_a_chan,
  output wire hb_a_phase,
  output wire hb_a_stb,
  output wire [1:0] hb_b_chan,
  output wire hb_b_phase,
  output wire hb_b_stb,
  output wire hb_a_port_en,
  output wire hb_b_port_en,
  output wire gain_a_bypass,
  output wire gain_a_clip_mode,
  output wire [2:0] gain_a_wlen,
  output reg gain_a_update,
  output reg gain_a_cic_clear,
  output reg [7:0] gain_a_level,
  output reg [11:0] gain_a_sgain,
  output reg [7:0] gain_a_kgain,
  output reg [7:0] gain_a_pole,
  output reg [5:0] gain_a_avg,
  output reg [11:0] gain_a_dec,
  output wire [7:0] gain_b_kgain,
  output wire [7:0] gain_b_pole,
  output wire [5:0] gain_b_avg,
  output wire [11:0] gain_b_dec,
  output wire [3:0] pp_a_chan_en,
  output wire [1:0] pp_a_gain_en,
  output wire pp_a_fmt8,
  output wire pp_a_src_gain,
  output wire [3:0] pp_b_chan_en,
  output wire [1:0] pp_b_gain_en,
  output wire pp_b_fmt8,
  output wire pp_b_src_gain,
  output wire lnk_a_en,
  output wire [3:0] lnk_a_wait,
  output wire lnk_a_no_rssi,
  output wire lnk_a_two_ch,
  output wire lnk_a_src_gain,
  output wire lnk_b_en,
  output wire [3:0] lnk_b_wait,
  output wire lnk_b_no_rssi,
  output wire lnk_b_two_ch,
  output wire lnk_b_src_gain,
  input wire port_clk_in,
  output reg port_clk_out,
  output wire port_clk_oe_n,
  output reg port_tick
);
  reg [7:0] channel_address_pointer;
  reg [3:0] halfband_a_port_ctrl;
  reg [2:0] halfband_b_port_ctrl;
  reg [7:0] gain_loop_a_ctrl;
  reg [15:0] gain_a_holdoff;
  reg [7:0] sh_level;
  reg [11:0] sh_sgain;
  reg [7:0] sh_kgain;
  reg [7:0] sh_pole;
  reg [5:0] sh_avg;
  reg [11:0] sh_dec;
  reg [7:0] gain_loop_b_open_gain;
  reg [7:0] gain_loop_b_pole;
  reg [5:0] gain_loop_b_averaging;
  reg [11:0] gain_loop_b_update_ratio;
  reg [5:0] parallel_port_a_ctrl;
  reg [7:0] serial_link_a_ctrl;
  reg [5:0] parallel_port_b_ctrl;
  reg [7:0] serial_link_b_ctrl;
  reg [2:0] output_port_clock_ctrl;
  reg [1:0] sync_meta;
  reg sync_prev;
  reg [1:0] pclk_meta;
  reg pclk_prev;
  reg [15:0] hold_cnt;
  reg synced_once;
  reg sync_now_req;
  reg [11:0] dec_cnt;
  reg [2:0] div_cnt;
  reg [15:0] next_rdata;
  wire acc_wr;
  wire sync_evt;
  wire sync_accept;
  wire sync_fire;
  wire dec_wrap;
  wire do_init;
  wire [1:0] hba_last;
  wire [1:0] hbb_last;
  wire [15:0] trunc_out;
  wire [22:0] trunc_in;
  wire [2:0] div_half;

  assign acc_wr = reg_wr && io_access_en;

  // register writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_address_pointer <= 8'h00;
      halfband_a_port_ctrl <= `OPAC_RST_HB;
      halfband_b_port_ctrl <= 3'h0;
      gain_loop_a_ctrl <= `OPAC_RST_GL_CTRL;
      gain_a_holdoff <= `OPAC_RST_HOLD;
      sh_level <= 8'h00;
      sh_sgain <= `OPAC_RST_PARAM;
      sh_kgain <= 8'h00;
      sh_pole <= 8'h00;
      sh_avg <= 6'h00;
      sh_dec <= `OPAC_RST_PARAM;
      gain_loop_b_open_gain <= 8'h00;
      gain_loop_b_pole <= 8'h00;
      gain_loop_b_averaging <= 6'h00;
      gain_loop_b_update_ratio <= `OPAC_RST_PARAM;
      parallel_port_a_ctrl <= `OPAC_RST_PP;
      serial_link_a_ctrl <= `OPAC_RST_LNK;
      parallel_port_b_ctrl <= `OPAC_RST_PP;
      serial_link_b_ctrl <= `OPAC_RST_LNK;
      output_port_clock_ctrl <= `OPAC_RST_PCLK;
      sync_now_req <= 1'b0;
    end else if (ce) begin
      sync_now_req <= 1'b0;
      if (ptr_wr && io_access_en) begin
        channel_address_pointer <= ptr_wdata;
      end
      if (acc_wr) begin
        case (channel_address_pointer)
          `OPAC_IDX_HB_A: halfband_a_port_ctrl <= reg_wdata[3:0];
          `OPAC_IDX_HB_B: halfband_b_port_ctrl <= reg_wdata[2:0];
          `OPAC_IDX_GLA_CTRL: begin
            gain_loop_a_ctrl <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
            sync_now_req <= reg_wdata[`OPAC_GL_SYNC_NOW];
          end
          `OPAC_IDX_GLA_HOLD: gain_a_holdoff <= reg_wdata;
          `OPAC_IDX_GLA_LEVEL: sh_level <= reg_wdata[7:0];
          `OPAC_IDX_GLA_SGAIN: sh_sgain <= reg_wdata[11:0];
          `OPAC_IDX_GLA_KGAIN: sh_kgain <= reg_wdata[7:0];
          `OPAC_IDX_GLA_POLE: sh_pole <= reg_wdata[7:0];
          `OPAC_IDX_GLA_AVG: sh_avg <= reg_wdata[5:0];
          `OPAC_IDX_GLA_DEC: sh_dec <= reg_wdata[11:0];
          `OPAC_IDX_GLB_KGAIN: gain_loop_b_open_gain <= reg_wdata[7:0];
          `OPAC_IDX_GLB_POLE: gain_loop_b_pole <= reg_wdata[7:0];
          `OPAC_IDX_GLB_AVG: gain_loop_b_averaging <= reg_wdata[5:0];
          `OPAC_IDX_GLB_DEC: gain_loop_b_update_ratio <= reg_wdata[11:0];
          `OPAC_IDX_PP_A: parallel_port_a_ctrl <= reg_wdata[5:0];
          `OPAC_IDX_LNK_A: serial_link_a_ctrl <= reg_wdata[7:0];
          `OPAC_IDX_PP_B: parallel_port_b_ctrl <= reg_wdata[5:0];
          `OPAC_IDX_LNK_B: serial_link_b_ctrl <= reg_wdata[7:0];
          `OPAC_IDX_PCLK: output_port_clock_ctrl <= reg_wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // read mux; sync-now bit reads as command still pending
  always @* begin
    case (channel_address_pointer)
      `OPAC_IDX_HB_A: next_rdata = {12'h000, halfband_a_port_ctrl};
      `OPAC_IDX_HB_B: next_rdata = {13'h0000, halfband_b_port_ctrl};
      `OPAC_IDX_GLA_CTRL: next_rdata = {8'h00, gain_loop_a_ctrl[7:4], sync_now_req, gain_loop_a_ctrl[2:0]};
      `OPAC_IDX_GLA_HOLD: next_rdata = gain_a_holdoff;
      `OPAC_IDX_GLA_LEVEL: next_rdata = {8'h00, sh_level};
      `OPAC_IDX_GLA_SGAIN: next_rdata = {4'h0, sh_sgain};
      `OPAC_IDX_GLA_KGAIN: next_rdata = {8'h00, sh_kgain};
      `OPAC_IDX_GLA_POLE: next_rdata = {8'h00, sh_pole};
      `OPAC_IDX_GLA_AVG: next_rdata = {10'h000, sh_avg};
      `OPAC_IDX_GLA_DEC: next_rdata = {4'h0, sh_dec};
      `OPAC_IDX_GLB_KGAIN: next_rdata = {8'h00, gain_loop_b_open_gain};
      `OPAC_IDX_GLB_POLE: next_rdata = {8'h00, gain_loop_b_pole};
      `OPAC_IDX_GLB_AVG: next_rdata = {10'h000, gain_loop_b_averaging};
      `OPAC_IDX_GLB_DEC: next_rdata = {4'h0, gain_loop_b_update_ratio};
      `OPAC_IDX_PP_A: next_rdata = {10'h000, parallel_port_a_ctrl};
      `OPAC_IDX_LNK_A: next_rdata = {8'h00, serial_link_a_ctrl};
      `OPAC_IDX_PP_B: next_rdata = {10'h000, parallel_port_b_ctrl};
      `OPAC_IDX_LNK_B: next_rdata = {8'h00, serial_link_b_ctrl};
      `OPAC_IDX_PCLK: next_rdata = {13'h0000, output_port_clock_ctrl};
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd && io_access_en;
      if (reg_rd && io_access_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // half-band sequencing
  // interleave code is last channel index
  assign hba_last = halfband_a_port_ctrl[`OPAC_HBA_IL_LSB+1:`OPAC_HBA_IL_LSB];
  // channel 2 alone or 2 and 3
  assign hbb_last = {1'b0, halfband_b_port_ctrl[`OPAC_HBB_IL]};
  assign hb_a_port_en = halfband_a_port_ctrl[`OPAC_HBA_EN];
  assign hb_b_port_en = halfband_b_port_ctrl[`OPAC_HBB_EN];

  opac_interleave #(.BASE(2'h0)) u_hb_a (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .slot_stb(slot_a_stb && hb_a_port_en),
    .last_idx(hba_last),
    .bypass(halfband_a_port_ctrl[`OPAC_HB_BYPASS]),
    .chan(hb_a_chan),
    .interp_phase(hb_a_phase),
    .out_stb(hb_a_stb)
  );

  opac_interleave #(.BASE(2'h2)) u_hb_b (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .slot_stb(slot_b_stb && hb_b_port_en),
    .last_idx(hbb_last),
    .bypass(halfband_b_port_ctrl[`OPAC_HB_BYPASS]),
    .chan(hb_b_chan),
    .interp_phase(hb_b_phase),
    .out_stb(hb_b_stb)
  );

  // gain loop A control
  assign gain_a_bypass = gain_loop_a_ctrl[`OPAC_GL_BYPASS];
  assign gain_a_clip_mode = gain_loop_a_ctrl[`OPAC_GL_CLIP_MODE];
  assign gain_a_wlen = gain_loop_a_ctrl[`OPAC_GL_WLEN_LSB+2:`OPAC_GL_WLEN_LSB];

  // sync pin synchroniser and edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= 2'h0;
      sync_prev <= 1'b0;
    end else if (ce) begin
      sync_meta <= {sync_meta[0], sync_pin};
      sync_prev <= sync_meta[1];
    end
  end
  assign sync_evt = (sync_meta[1] && !sync_prev) || soft_sync;
  // later syncs ignored in first-only mode
  assign sync_accept = sync_evt && (gain_a_holdoff != 16'h0000) &&
    !(gain_loop_a_ctrl[`OPAC_GL_FIRST_ONLY] && synced_once);
  assign sync_fire = (sync_accept && gain_a_holdoff == 16'h0001) || (hold_cnt == 16'h0001);
  assign do_init = (sync_fire || sync_now_req) && gain_loop_a_ctrl[`OPAC_GL_INIT_SYNC];
  assign dec_wrap = sample_a_valid && (dec_cnt >= gain_a_dec);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt <= 16'h0000;
      synced_once <= 1'b0;
      dec_cnt <= 12'h000;
      gain_a_update <= 1'b0;
      gain_a_cic_clear <= 1'b0;
      gain_a_level <= 8'h00;
      gain_a_sgain <= `OPAC_RST_PARAM;
      gain_a_kgain <= 8'h00;
      gain_a_pole <= 8'h00;
      gain_a_avg <= 6'h00;
      gain_a_dec <= `OPAC_RST_PARAM;
    end else if (ce) begin
      if (sync_accept && gain_a_holdoff != 16'h0001) begin
        hold_cnt <= gain_a_holdoff;
      end else if (hold_cnt != 16'h0000) begin
        hold_cnt <= hold_cnt - 16'h0001;
      end
      // first-only memory, rearmed by control write
      if (sync_fire) begin
        synced_once <= 1'b1;
      end else if (acc_wr && channel_address_pointer == `OPAC_IDX_GLA_CTRL) begin
        synced_once <= 1'b0;
      end
      // update and restart on each fired sync, sync-now command or decimation wrap
      gain_a_update <= sync_fire || sync_now_req || dec_wrap;
      gain_a_cic_clear <= do_init;
      if (sync_fire || sync_now_req || dec_wrap) begin
        dec_cnt <= 12'h000;
      end else if (sample_a_valid) begin
        dec_cnt <= dec_cnt + 12'h001;
      end
      if (do_init) begin
        gain_a_level <= sh_level;
        gain_a_sgain <= sh_sgain;
        gain_a_kgain <= sh_kgain;
        gain_a_pole <= sh_pole;
        gain_a_avg <= sh_avg;
        gain_a_dec <= sh_dec;
      end
    end
  end

  assign trunc_in = gain_a_bypass ? hb_a_sample : gain_a_sample;
  opac_truncate u_trunc_a (
    .din(trunc_in),
    .wlen_code(gain_a_wlen),
    .dout(trunc_out)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_a_data <= 16'h0000;
      out_a_valid <= 1'b0;
    end else if (ce) begin
      out_a_valid <= sample_a_valid;
      if (sample_a_valid) begin
        out_a_data <= trunc_out;
      end
    end
  end

  assign gain_b_kgain = gain_loop_b_open_gain;
  assign gain_b_pole = gain_loop_b_pole;
  assign gain_b_avg = gain_loop_b_averaging;
  assign gain_b_dec = gain_loop_b_update_ratio;

  // parallel ports
  // source select
  assign pp_a_src_gain = parallel_port_a_ctrl[`OPAC_PP_SRC];
  assign pp_b_src_gain = parallel_port_b_ctrl[`OPAC_PP_SRC];
  assign pp_a_fmt8 = parallel_port_a_ctrl[`OPAC_PP_FMT8];
  assign pp_b_fmt8 = parallel_port_b_ctrl[`OPAC_PP_FMT8];
  assign pp_a_chan_en = pp_a_src_gain ? 4'h0 : parallel_port_a_ctrl[`OPAC_PP_EN_LSB+3:`OPAC_PP_EN_LSB];
  assign pp_a_gain_en = pp_a_src_gain ? parallel_port_a_ctrl[`OPAC_PP_EN_LSB+1:`OPAC_PP_EN_LSB] : 2'h0;
  assign pp_b_chan_en = pp_b_src_gain ? 4'h0 : parallel_port_b_ctrl[`OPAC_PP_EN_LSB+3:`OPAC_PP_EN_LSB];
  assign pp_b_gain_en = pp_b_src_gain ? parallel_port_b_ctrl[`OPAC_PP_EN_LSB+1:`OPAC_PP_EN_LSB] : 2'h0;

  // link ports
  // enable and wait
  assign lnk_a_en = serial_link_a_ctrl[`OPAC_LK_EN];
  assign lnk_a_wait = serial_link_a_ctrl[`OPAC_LK_WAIT_LSB+3:`OPAC_LK_WAIT_LSB];
  assign lnk_b_en = serial_link_b_ctrl[`OPAC_LK_EN];
  assign lnk_b_wait = serial_link_b_ctrl[`OPAC_LK_WAIT_LSB+3:`OPAC_LK_WAIT_LSB];
  assign lnk_a_no_rssi = serial_link_a_ctrl[`OPAC_LK_NO_RSSI];
  assign lnk_b_no_rssi = serial_link_b_ctrl[`OPAC_LK_NO_RSSI];
  assign lnk_a_two_ch = serial_link_a_ctrl[`OPAC_LK_TWO_CH];
  assign lnk_b_two_ch = serial_link_b_ctrl[`OPAC_LK_TWO_CH];
  assign lnk_a_src_gain = serial_link_a_ctrl[`OPAC_LK_SRC];
  assign lnk_b_src_gain = serial_link_b_ctrl[`OPAC_LK_SRC];

  // port clock: slave samples pin, master divides clk
  // direction and divisor
  assign port_clk_oe_n = !output_port_clock_ctrl[`OPAC_PC_MASTER];
  assign div_half = (3'h1 << output_port_clock_ctrl[`OPAC_PC_DIV_LSB+1:`OPAC_PC_DIV_LSB]) - 3'h1;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pclk_meta <= 2'h0;
      pclk_prev <= 1'b0;
      div_cnt <= 3'h0;
      port_clk_out <= 1'b0;
      port_tick <= 1'b0;
    end else if (ce) begin
      pclk_meta <= {pclk_meta[0], port_clk_in};
      pclk_prev <= pclk_meta[1];
      if (output_port_clock_ctrl[`OPAC_PC_MASTER]) begin
        if (div_cnt >= div_half) begin
          div_cnt <= 3'h0;
          port_clk_out <= !port_clk_out;
          port_tick <= !port_clk_out;
        end else begin
          div_cnt <= div_cnt + 3'h1;
          port_tick <= 1'b0;
        end
      end else begin
        div_cnt <= 3'h0;
        port_clk_out <= 1'b0;
        port_tick <= pclk_meta[1] && !pclk_prev;
      end
    end
  end
endmodule // opac_output_ctrl

// ==== opac_rake.sv ====
// opac_rake.sv: downstream processor model, paces slots, runs slave port clock
// assumes: clk is the block clock; run opens a frame of port clock
`timescale 1ns/1ps
module opac_rake (
  input logic clk,
  input logic run,
  input logic port_clk_oe_n,
  input logic port_clk_out,
  output logic port_clk_in,
  output logic slot_a_stb = 1'b0,
  output logic slot_b_stb = 1'b0
);
  logic pc = 1'b0;
  logic [1:0] div = 2'h0;
  // port clock stands still outside frames
  always #40 pc = run ? ~pc : 1'b0;
  assign port_clk_in = port_clk_oe_n ? pc : port_clk_out;
  always @(posedge clk) begin
    div <= div + 2'h1;
    slot_a_stb <= #1 div == 2'h3;
    slot_b_stb <= #1 div == 2'h1;
  end
endmodule // opac_rake

// ==== opac_sva.sv ====
// opac_sva.sv: port-level checks of opac_output_ctrl
// assumes: bound to the top module, sees its ports only
`timescale 1ns/1ps
module opac_sva (
  input logic clk,
  input logic rstn,
  input logic ce,
  input logic io_access_en,
  input logic reg_rd,
  input logic reg_rvalid,
  input logic [15:0] reg_rdata,
  input logic sample_a_valid,
  input logic out_a_valid,
  input logic [15:0] out_a_data,
  input logic [2:0] gain_a_wlen,
  input logic slot_a_stb,
  input logic hb_a_stb,
  input logic hb_a_port_en,
  input logic pp_a_src_gain,
  input logic [3:0] pp_a_chan_en,
  input logic port_clk_oe_n,
  input logic port_clk_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_taken; ce && io_access_en && reg_rd; endsequence
  sequence smp_taken; ce && sample_a_valid; endsequence
  a_read_answer: assert property (rd_taken |=> reg_rvalid) else $error("read not answered");
  a_read_blocked: assert property (!io_access_en && reg_rd |=> !reg_rvalid) else $error("blocked read answered");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  a_trunc_valid: assert property (smp_taken |=> out_a_valid) else $error("sample not output");
  a_width_four: assert property (out_a_valid && gain_a_wlen == 3'h7 |-> out_a_data[11:0] == 12'h000)
    else $error("4-bit width wrong");
  a_width_eight: assert property (out_a_valid && gain_a_wlen == 3'h3 |-> out_a_data[7:0] == 8'h00)
    else $error("8-bit width wrong");
  a_slot_gate: assert property (hb_a_stb |-> $past(slot_a_stb && hb_a_port_en)) else $error("strobe without slot");
  a_src_split: assert property (pp_a_src_gain |-> pp_a_chan_en == 4'h0) else $error("channel enable in gain source");
  a_slave_quiet: assert property (port_clk_oe_n && $past(port_clk_oe_n) |-> !port_clk_out)
    else $error("slave drives clock");
endmodule // opac_sva

// ==== opac_truncate.v ====
// opac_truncate.v: cuts a 23-bit sample to the programmed output word width
// assumes: combinational, result msb-aligned in 16 bits, low bits zero
`timescale 1ns/1ps
`include "opac_defs.vh"
module opac_truncate (
  input wire [22:0] din,
  input wire [2:0] wlen_code,
  output reg [15:0] dout
);
  reg [15:0] keep_mask;
  always @* begin
    case (wlen_code)
      3'h7: keep_mask = 16'hF000;
      3'h6: keep_mask = 16'hF800;
      3'h5: keep_mask = 16'hFC00;
      3'h4: keep_mask = 16'hFE00;
      3'h3: keep_mask = 16'hFF00;
      3'h2: keep_mask = 16'hFFC0;
      3'h1: keep_mask = 16'hFFF0;
      default: keep_mask = 16'hFFFF;
    endcase
    dout = din[22:7] & keep_mask;
  end
endmodule // opac_truncate

// ==== tb_top.sv ====
// tb_top.sv: register-level tests of opac_output_ctrl with a rake model
// assumes: 250 MHz clk, inputs driven 1 ns after each rising edge
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rstn = 0, ce = 1, io_access_en = 0, ptr_wr = 0, reg_wr = 0, reg_rd = 0;
  logic sync_pin = 0, soft_sync = 0, sample_a_valid = 0, run = 0;
  logic [7:0] ptr_wdata = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [22:0] hb_a_sample = 23'h7FFFFF, gain_a_sample = 23'h000000;
  wire hb_a_phase, hb_a_stb, hb_b_phase, hb_b_stb, hb_a_port_en, hb_b_port_en, gain_a_bypass, gain_a_clip_mode;
  wire gain_a_update, gain_a_cic_clear, pp_a_fmt8, pp_a_src_gain, pp_b_fmt8, pp_b_src_gain, lnk_a_en;
  wire lnk_a_no_rssi, lnk_a_two_ch, lnk_a_src_gain, lnk_b_en, lnk_b_no_rssi, lnk_b_two_ch, lnk_b_src_gain;
  wire port_clk_in, port_clk_out, port_clk_oe_n, port_tick, slot_a_stb, slot_b_stb, reg_rvalid, out_a_valid;
  wire [1:0] hb_a_chan, hb_b_chan, pp_a_gain_en, pp_b_gain_en;
  wire [2:0] gain_a_wlen;
  wire [3:0] pp_a_chan_en, pp_b_chan_en, lnk_a_wait, lnk_b_wait;
  wire [5:0] gain_a_avg, gain_b_avg;
  wire [7:0] gain_a_level, gain_a_kgain, gain_a_pole, gain_b_kgain, gain_b_pole;
  wire [11:0] gain_a_sgain, gain_a_dec, gain_b_dec;
  wire [15:0] reg_rdata, out_a_data;
  int errors = 0, total_checks = 0, n, n1, t, i, np;
  logic cl;
  logic [1:0] m;
  logic [7:0] ra [12] = '{8'h08, 8'h09, 8'h0B, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h20};
  logic [15:0] rm [12] = '{16'h000F, 16'h0007, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h003F, 16'h0FFF, 16'h003F,
    16'h00FF, 16'h003F, 16'h00FF, 16'h0000};
  logic [4:0] wl [8] = '{5'h10, 5'h0C, 5'h0A, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
  opac_output_ctrl DUT (.*);
  opac_rake rake (.*);
  initial forever #2 clk = ~clk;
  task close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task ck(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    ptr_wr = 1; ptr_wdata = a;
    @(posedge clk); #1 ptr_wr = 0; reg_wr = 1; reg_wdata = d;
    @(posedge clk); #1 reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    ptr_wr = 1; ptr_wdata = a;
    @(posedge clk); #1 ptr_wr = 0; reg_rd = 1;
    @(posedge clk); #1 reg_rd = 0;
    ck(reg_rvalid ? reg_rdata : 16'hDEAD, e);
  endtask
  task sy(input logic s, output int k, output logic c);
    soft_sync = s; k = 0; c = 0;
    @(posedge clk); #1 soft_sync = 0;
    while (k < 9 && gain_a_update !== 1'b1) begin
      c |= gain_a_cic_clear;
      @(posedge clk); #1 k++;
    end
    c |= gain_a_cic_clear;
  endtask
  task hb(input logic b, output logic [1:0] mx);
    logic [1:0] c;
    mx = 2'h0;
    np = 0;
    repeat (32) begin
      @(posedge clk); #1 c = b ? hb_b_chan : hb_a_chan;
      if ((b ? hb_b_stb : hb_a_stb) === 1'b1) begin
        np += (b ? hb_b_phase : hb_a_phase);
        if (c > mx) mx = c;
      end
    end
  endtask
  task tk(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(posedge clk); #1 k += port_tick;
    end
  endtask
  initial begin
    #100000 errors++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    ck(16'(port_clk_oe_n), 16'h0001);
    wr(8'h1B, 16'h00FF);
    rd(8'h1B, 16'hDEAD);
    io_access_en = 1;
    rd(8'h1B, 16'h0000);
    for (i = 0; i < 12; i++) rd(ra[i], 16'h0000);
    for (i = 0; i < 12; i++) begin
      wr(ra[i], 16'hFFFF);
      rd(ra[i], rm[i]);
    end
    ck({pp_a_fmt8, pp_a_src_gain, pp_a_gain_en, pp_a_chan_en, lnk_a_en, lnk_a_wait, lnk_a_no_rssi, lnk_a_two_ch,
      lnk_a_src_gain}, 16'hF0FF);
    ck({pp_b_fmt8, pp_b_src_gain, pp_b_gain_en, pp_b_chan_en, lnk_b_en, lnk_b_wait, lnk_b_no_rssi, lnk_b_two_ch,
      lnk_b_src_gain}, 16'hF0FF);
    ck({gain_b_kgain, gain_b_pole}, 16'hFFFF);
    ck({gain_b_avg, gain_b_dec[9:0]}, 16'hFFFF);
    for (i = 8'h1A; i < 8'h1E; i += 2) wr(8'(i), 16'h002A);
    for (i = 8'h1B; i < 8'h1E; i += 2) wr(8'(i), 16'h0048);
    ck({pp_a_fmt8, pp_a_src_gain, pp_a_gain_en, pp_a_chan_en, lnk_a_en, lnk_a_wait, lnk_a_no_rssi, lnk_a_two_ch,
      lnk_a_src_gain}, 16'h8548);
    ck({pp_b_fmt8, pp_b_src_gain, pp_b_gain_en, pp_b_chan_en, lnk_b_en, lnk_b_wait, lnk_b_no_rssi, lnk_b_two_ch,
      lnk_b_src_gain}, 16'h8548);
    for (i = 0; i < 9; i++) begin
      wr(8'h0A, i < 8 ? 16'({i[2:0], 5'h01}) : 16'h0010);
      sample_a_valid = 1;
      @(posedge clk); #1 sample_a_valid = 0;
      ck(out_a_valid ? out_a_data : 16'h0BAD, i < 8 ? 16'(16'hFFFF << (16 - wl[i])) : 16'h0000);
    end
    ck(16'(gain_a_clip_mode), 16'h0001);
    for (i = 0; i < 4; i++) begin
      wr(8'h08, 16'(9 + 2 * i));
      hb(0, m);
      ck(16'(m), 16'(i));
      ck(16'(np), 16'h0000);
    end
    wr(8'h08, 16'h000E);
    hb(0, m);
    ck(16'(m), 16'h0003);
    ck(16'(np), 16'h0004);
    wr(8'h09, 16'h0005);
    hb(1, m);
    ck(16'(m), 16'h0002);
    wr(8'h09, 16'h0007);
    hb(1, m);
    ck(16'(m), 16'h0003);
    ck(16'(np), 16'h0000);
    wr(8'h0B, 16'h0001);
    wr(8'h0E, 16'h005A);
    wr(8'h11, 16'h0ABC);
    wr(8'h0A, 16'h0004);
    sy(1, n1, cl);
    ck(16'(n1 <= 2 && cl), 16'h0001);
    ck(16'(gain_a_kgain), 16'h005A);
    ck(16'(gain_a_dec), 16'h0ABC);
    wr(8'h0E, 16'h00A5);
    wr(8'h0A, 16'h0000);
    sy(1, n, cl);
    ck(16'(n == n1 && !cl && gain_a_kgain == 8'h5A), 16'h0001);
    wr(8'h0B, 16'h0003);
    sy(1, n, cl);
    ck(16'(n), 16'(n1 + 3));
    wr(8'h0B, 16'h0001);
    wr(8'h0A, 16'h0002);
    sy(1, n, cl);
    ck(16'(n), 16'(n1));
    sy(1, n, cl);
    ck(16'(n), 16'h0009);
    wr(8'h0A, 16'h0008);
    sy(0, n, cl);
    ck(16'(n <= 3), 16'h0001);
    sync_pin = 1;
    sy(0, n, cl);
    sync_pin = 0;
    ck(16'(n), 16'h0002);
    wr(8'h0B, 16'h0000);
    wr(8'h0A, 16'h0000);
    sy(1, n, cl);
    ck(16'(n), 16'h0009);
    wr(8'h1E, 16'h0003);
    tk(40, t);
    ck(16'(t >= 9 && t <= 11 && port_clk_oe_n === 1'b0), 16'h0001);
    wr(8'h1E, 16'h0000);
    run = 1;
    tk(200, t);
    run = 0;
    ck(16'(t >= 9 && t <= 11), 16'h0001);
    close_out;
  end
endmodule // tb_top
bind opac_output_ctrl opac_sva chk (.*);
